/* File: hdl/sirp_dev.sv */
// Two-wire slave end: address match, byte framing, index increment, stretching
`timescale 1ns/100ps
`include "sirp_params.svh"
module sirp_dev (
    input  wire logic        clk,
    input  wire logic        resetn,
    sirp_if.dev              bus,
    input  wire logic        addr_lsb_strap,
    input  wire logic        two_wire_port_disable,
    output logic             wr_strobe,
    output logic [7:0]       wr_index,
    output logic [7:0]       wr_data,
    output logic             rd_req,
    output logic [7:0]       rd_index,
    input  wire logic        rd_valid,
    input  wire logic [7:0]  rd_data,
    output logic             bus_busy
);
    import sirp_pkg::*;

    sirp_dev_st_t state;
    logic [3:0]   bit_cnt;
    logic [7:0]   shift;
    logic [7:0]   tx;
    logic [7:0]   register_index;
    logic [7:0]   rd_idx_l;
    logic [7:0]   wr_idx_l;
    logic [7:0]   wr_dat_l;
    logic [7:0]   rd_hold;
    logic         start_tog;
    logic         stop_tog;
    logic         start_seen;
    logic         ack_due;
    logic         rd_tog;
    logic         wr_tog;
    logic         sda_drv;
    logic [1:0]   cfg_m;
    logic [1:0]   cfg;
    logic [4:0]   x_m;
    logic [4:0]   x_s;
    logic [4:0]   x_h;
    logic         rd_done;
    logic         stretch;

    // Start and stop seen on SDA edges while SCL is high
    always_ff @(negedge bus.sda or negedge resetn) begin
        if (!resetn)
            start_tog <= 1'b0;
        else if (bus.scl)
            start_tog <= ~start_tog;
    end

    always_ff @(posedge bus.sda or negedge resetn) begin
        if (!resetn)
            stop_tog <= 1'b0;
        else if (bus.scl)
            stop_tog <= ~stop_tog;
    end

    // Strap and disable pass two link-clock flops
    always_ff @(posedge bus.scl or negedge resetn) begin
        if (!resetn) begin
            cfg_m <= 2'h0;
            cfg   <= 2'h0;
        end else begin
            cfg_m <= {two_wire_port_disable, addr_lsb_strap};
            cfg   <= cfg_m;
        end
    end

    // Link-side decode
    wire       new_frame = start_tog != start_seen;
    wire [7:0] rx_byte   = {shift[6:0], bus.sda};
    wire       byte_end  = bit_cnt == `SIRP_LAST_BIT;
    wire       ack_slot  = bit_cnt == `SIRP_ACK_SLOT;
    wire [6:0] own_addr  = {`SIRP_ADDR_HI, cfg[0]};
    wire       hit       = rx_byte[7:1] == own_addr && !cfg[1];
    wire       is_read   = rx_byte[0] == `SIRP_DIR_READ;
    wire       m_ack     = !bus.sda;
    wire       tx_bit    = tx[~bit_cnt[2:0]];

    // Bit counter and shifter, sampled on the rising clock
    always_ff @(posedge bus.scl or negedge resetn) begin
        if (!resetn) begin
            bit_cnt    <= 4'h0;
            shift      <= 8'h00;
            start_seen <= 1'b0;
        end else if (new_frame) begin
            start_seen <= start_tog;
            bit_cnt    <= 4'h1;
            shift      <= {7'h00, bus.sda};
        end else if (ack_slot) begin
            bit_cnt <= 4'h0;
        end else begin
            bit_cnt <= bit_cnt + 4'h1;
            shift   <= rx_byte;
        end
    end

    // Transfer sequence
    always_ff @(posedge bus.scl or negedge resetn) begin
        if (!resetn) begin
            state   <= dev_idle;
            ack_due <= 1'b0;
        end else if (new_frame) begin
            state   <= dev_addr;
            ack_due <= 1'b0;
        end else if (ack_slot) begin
            ack_due <= 1'b0;
            if (state == dev_rfirst)
                state <= dev_rdata;
            else if (state == dev_rdata && !m_ack)
                state <= dev_idle;
        end else if (byte_end) begin
            unique case (state)
                dev_addr: begin
                    ack_due <= hit;
                    if (!hit)
                        state <= dev_idle;
                    else if (is_read)
                        state <= dev_rfirst;
                    else
                        state <= dev_index;
                end
                dev_index: begin
                    ack_due <= 1'b1;
                    state   <= dev_wdata;
                end
                dev_wdata: begin
                    ack_due <= 1'b1;
                end
                dev_idle, dev_rfirst, dev_rdata: begin
                    ack_due <= 1'b0;
                end
            endcase
        end
    end

    // Register index, write capture and read prefetch
    always_ff @(posedge bus.scl or negedge resetn) begin
        if (!resetn) begin
            register_index <= 8'h00;
            tx             <= 8'h00;
            rd_tog         <= 1'b0;
            wr_tog         <= 1'b0;
            rd_idx_l       <= 8'h00;
            wr_idx_l       <= 8'h00;
            wr_dat_l       <= 8'h00;
        end else if (new_frame) begin
            tx <= tx;
        end else if (ack_slot) begin
            if (state == dev_rfirst)
                tx <= rd_hold;
            else if (state == dev_rdata && m_ack) begin
                register_index <= register_index + 8'h01;
                tx             <= rd_hold;
            end
        end else if (byte_end) begin
            if (state == dev_index)
                register_index <= rx_byte;
            else if (state == dev_wdata) begin
                wr_tog         <= ~wr_tog;
                wr_idx_l       <= register_index;
                wr_dat_l       <= rx_byte;
                register_index <= register_index + 8'h01;
            end else if (state == dev_addr && hit && is_read) begin
                rd_tog   <= ~rd_tog;
                rd_idx_l <= register_index;
            end else if (state == dev_rdata) begin
                rd_tog   <= ~rd_tog;
                rd_idx_l <= register_index + 8'h01;
            end
        end
    end

    // SDA driven only on the falling clock
    always_ff @(negedge bus.scl or negedge resetn) begin
        if (!resetn)
            sda_drv <= 1'b0;
        else if (ack_slot)
            sda_drv <= ack_due;
        else
            sda_drv <= state == dev_rdata && !tx_bit;
    end

    // Link toggles and SCL level enter the local clock over two flops
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            x_m <= 5'h00;
            x_s <= 5'h00;
            x_h <= 5'h00;
        end else begin
            x_m <= {bus.scl, stop_tog, start_tog, wr_tog, rd_tog};
            x_s <= x_m;
            x_h <= x_s;
        end
    end

    wire wr_edge    = x_s[1] ^ x_h[1];
    wire start_edge = x_s[2] ^ x_h[2];
    wire stop_edge  = x_s[3] ^ x_h[3];
    wire scl_s      = x_s[4];
    wire rd_edge    = x_s[0] ^ x_h[0];
    wire pending    = x_s[0] != rd_done;
    wire serve      = pending && !rd_edge && rd_valid;
    wire next_hold  = pending && !serve && (stretch || !scl_s);

    // Local-side strobes and bus busy flag, start wins over stop
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_strobe <= 1'b0;
            wr_index  <= 8'h00;
            wr_data   <= 8'h00;
            rd_req    <= 1'b0;
            rd_index  <= 8'h00;
            bus_busy  <= 1'b0;
        end else begin
            wr_strobe <= wr_edge;
            rd_req    <= rd_edge;
            if (wr_edge) begin
                wr_index <= wr_idx_l;
                wr_data  <= wr_dat_l;
            end
            if (rd_edge)
                rd_index <= rd_idx_l;
            if (start_edge)
                bus_busy <= 1'b1;
            else if (stop_edge)
                bus_busy <= 1'b0;
        end
    end

    // Read answer capture and clock stretch while it is awaited
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rd_done <= 1'b0;
            rd_hold <= 8'h00;
            stretch <= 1'b0;
        end else begin
            stretch <= next_hold;
            if (serve) begin
                rd_done <= x_s[0];
                rd_hold <= rd_data;
            end
        end
    end

    // Open-drain drivers only ever pull low
    assign bus.dev_scl_o  = 1'b0;
    assign bus.dev_scl_oe = stretch;
    assign bus.dev_sda_o  = 1'b0;
    assign bus.dev_sda_oe = sda_drv;
endmodule : sirp_dev

/* File: hdl/sirp_host.sv */
// Two-wire master end: drives transfers from a simple command port
`timescale 1ns/100ps
`include "sirp_params.svh"
module sirp_host #(
    parameter int QTR_CYC = `SIRP_QTR_CYC,
    parameter int CNT_W   = 4
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    sirp_if.host                  bus,
    input  wire logic             cmd_valid,
    output logic                  cmd_ready,
    input  wire logic             cmd_read,
    input  wire logic             cmd_addr_lsb,
    input  wire logic [7:0]       cmd_index,
    input  wire logic [CNT_W-1:0] cmd_count,
    input  wire logic [7:0]       wr_data,
    output logic                  wr_take,
    output logic [7:0]            rd_data,
    output logic                  rd_valid,
    output logic                  done,
    output logic                  nack_err
);
    import sirp_pkg::*;

    localparam int             TW       = $clog2(QTR_CYC + 1);
    localparam logic [TW-1:0]  QTR_LAST = TW'(QTR_CYC - 1);
    localparam logic [CNT_W-1:0] ONE    = CNT_W'(1);

    if (QTR_CYC < 2 || CNT_W < 1) begin : g_bad_param
        $error("sirp_host: QTR_CYC must be >= 2 and CNT_W >= 1");
    end

    sirp_op_t         op;
    sirp_step_t       step;
    logic [1:0]       ph;
    logic [TW-1:0]    tick;
    logic [3:0]       bit_cnt;
    logic [7:0]       sh;
    logic             tx_mode;
    logic             host_ack;
    logic             rd_mode;
    logic             lsb;
    logic [7:0]       idx;
    logic [CNT_W-1:0] left;
    logic             scl_drv;
    logic             sda_drv;
    logic [1:0]       pin_m;
    logic [1:0]       pin_s;

    // Bus pins pass two flops
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pin_m <= 2'h3;
            pin_s <= 2'h3;
        end else begin
            pin_m <= {bus.scl, bus.sda};
            pin_s <= pin_m;
        end
    end

    // Phase timing; a released SCL held low by the slave stalls the count
    wire scl_s    = pin_s[1];
    wire sda_s    = pin_s[0];
    wire stall    = !scl_drv && !scl_s;
    wire tick_end = tick == QTR_LAST && !stall;
    wire op_end   = tick_end && ph == 2'h3 && (op != op_bit || bit_cnt == `SIRP_ACK_SLOT);
    wire bit_val  = bit_cnt == `SIRP_ACK_SLOT ? (!tx_mode && host_ack) : (tx_mode && !sh[7]);
    wire last     = left == ONE;

    // Pin levels wanted for each operation phase
    wire want_scl = op == op_bit   ? ph < 2'h2 :
                    op == op_stop  ? ph < 2'h2 :
                    op == op_start ? (ph == 2'h0 && step == stp_addr_r) : 1'b0;
    wire want_sda = op == op_bit   ? (ph == 2'h0 ? sda_drv : bit_val) :
                    op == op_stop  ? (ph == 2'h0 ? sda_drv : ph != 2'h3) :
                    op == op_start ? ph >= 2'h2 : 1'b0;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tick    <= '0;
            ph      <= 2'h0;
            scl_drv <= 1'b0;
            sda_drv <= 1'b0;
        end else begin
            scl_drv <= want_scl;
            sda_drv <= want_sda;
            if (op == op_idle || op_end) begin
                tick <= '0;
                ph   <= 2'h0;
            end else if (tick_end) begin
                tick <= '0;
                ph   <= ph + 2'h1;
            end else if (!stall) begin
                tick <= tick + TW'(1);
            end
        end
    end

    // Transfer sequencing
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            op <= op_idle; step <= stp_addr_w; bit_cnt <= 4'h0; sh <= 8'h00;
            tx_mode <= 1'b1; host_ack <= 1'b0; rd_mode <= 1'b0; lsb <= 1'b0;
            idx <= 8'h00; left <= ONE; cmd_ready <= 1'b0; wr_take <= 1'b0;
            rd_data <= 8'h00; rd_valid <= 1'b0; done <= 1'b0; nack_err <= 1'b0;
        end else begin
            wr_take  <= 1'b0;
            rd_valid <= 1'b0;
            done     <= 1'b0;
            if (op == op_idle) begin
                cmd_ready <= 1'b1;
                if (cmd_valid && cmd_ready) begin
                    cmd_ready <= 1'b0;
                    rd_mode   <= cmd_read;
                    lsb       <= cmd_addr_lsb;
                    idx       <= cmd_index;
                    left      <= cmd_count == '0 ? ONE : cmd_count;
                    nack_err  <= 1'b0;
                    step      <= stp_addr_w;
                    op        <= op_start;
                end
            end else if (op == op_bit && tick_end && ph == 2'h3 && !op_end) begin
                bit_cnt <= bit_cnt + 4'h1;
                sh      <= {sh[6:0], sda_s};
            end else if (op_end) begin
                op      <= op_bit;
                bit_cnt <= 4'h0;
                tx_mode <= 1'b1;
                unique case (op)
                    op_start: begin
                        sh <= {`SIRP_ADDR_HI, lsb, step == stp_addr_r};
                    end
                    op_stop: begin
                        op   <= op_idle;
                        done <= 1'b1;
                    end
                    op_bit: begin
                        if (tx_mode && sda_s) begin
                            nack_err <= 1'b1;
                            op       <= op_stop;
                        end else begin
                            unique case (step)
                                stp_addr_w: begin
                                    sh   <= idx;
                                    step <= stp_index;
                                end
                                stp_index, stp_wdata: begin
                                    if (rd_mode) begin
                                        step <= stp_addr_r;
                                        op   <= op_start;
                                    end else if (step == stp_wdata && last) begin
                                        op <= op_stop;
                                    end else begin
                                        sh      <= wr_data;
                                        wr_take <= 1'b1;
                                        step    <= stp_wdata;
                                        if (step == stp_wdata)
                                            left <= left - ONE;
                                    end
                                end
                                stp_addr_r: begin
                                    tx_mode  <= 1'b0;
                                    host_ack <= !last;
                                    step     <= stp_rdata;
                                end
                                stp_rdata: begin
                                    rd_data  <= sh;
                                    rd_valid <= 1'b1;
                                    tx_mode  <= 1'b0;
                                    left     <= left - ONE;
                                    host_ack <= left > CNT_W'(2);
                                    if (last)
                                        op <= op_stop;
                                end
                            endcase
                        end
                    end
                    op_idle: begin
                        op <= op_idle;
                    end
                endcase
            end
        end
    end

    assign bus.host_scl_o  = 1'b0;
    assign bus.host_scl_oe = scl_drv;
    assign bus.host_sda_o  = 1'b0;
    assign bus.host_sda_oe = sda_drv;
endmodule : sirp_host

/* File: pkg/sirp_if.sv */
// Open-drain two-wire bus joining the master end and the slave end
`timescale 1ns/100ps
interface sirp_if;
    logic host_scl_o;
    logic host_scl_oe;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_scl_o;
    logic dev_scl_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic scl;
    logic sda;

    // Wired-AND of both drivers with pull-ups
    assign scl = (host_scl_oe ? host_scl_o : 1'b1) & (dev_scl_oe ? dev_scl_o : 1'b1);
    assign sda = (host_sda_oe ? host_sda_o : 1'b1) & (dev_sda_oe ? dev_sda_o : 1'b1);

    modport host (
        input  scl,
        input  sda,
        output host_scl_o,
        output host_scl_oe,
        output host_sda_o,
        output host_sda_oe
    );

    modport dev (
        input  scl,
        input  sda,
        output dev_scl_o,
        output dev_scl_oe,
        output dev_sda_o,
        output dev_sda_oe
    );
endinterface : sirp_if

/* File: pkg/sirp_params.svh */
// Timing, address and framing constants of the two-wire register port
`ifndef SIRP_PARAMS_SVH
`define SIRP_PARAMS_SVH

// Fixed upper six bits of the seven-bit slave address
`define SIRP_ADDR_HI      6'h34
// Direction bit values
`define SIRP_DIR_WRITE    1'b0
`define SIRP_DIR_READ     1'b1
// Bit slots of one byte and position of the acknowledge slot
`define SIRP_LAST_BIT     4'h7
`define SIRP_ACK_SLOT     4'h8
// Fastest serial clock and the local clock rate
`define SIRP_SCL_MAX_KHZ  400
`define SIRP_CLK_MHZ      125
// Quarter bit in local cycles, rounded up so the clock never runs fast
`define SIRP_QTR_CYC      ((1000 * `SIRP_CLK_MHZ + 4 * `SIRP_SCL_MAX_KHZ - 1) / (4 * `SIRP_SCL_MAX_KHZ))

`endif

/* File: pkg/sirp_pkg.sv */
// Types shared by both ends of the two-wire register port
package sirp_pkg;

    // Slave link-side sequence
    typedef enum logic [2:0] {
        dev_idle,
        dev_addr,
        dev_index,
        dev_wdata,
        dev_rfirst,
        dev_rdata
    } sirp_dev_st_t;

    // Master bus operation in progress
    typedef enum logic [1:0] {
        op_idle,
        op_start,
        op_bit,
        op_stop
    } sirp_op_t;

    // Master byte within one transfer
    typedef enum logic [2:0] {
        stp_addr_w,
        stp_index,
        stp_wdata,
        stp_addr_r,
        stp_rdata
    } sirp_step_t;

endpackage : sirp_pkg

/* File: test/sirp_chk.sv */
// Concurrent checks on the two-wire bus between the master and slave ends
`timescale 1ns/100ps
`include "sirp_params.svh"
module sirp_chk (
    input wire logic clk,
    input wire logic resetn,
    input wire logic scl,
    input wire logic sda,
    input wire logic dev_scl_oe,
    input wire logic dev_sda_oe,
    input wire logic addr_lsb_strap,
    input wire logic two_wire_port_disable,
    input wire logic bus_busy
);
    logic       scl_q;
    logic       sda_q;
    logic [3:0] pos;
    logic [7:0] sh;
    logic       first;
    logic       sel;
    logic       rd;
    logic       quiet;
    logic       nacked;

    // Line events seen on the local clock
    wire start_ev = scl && scl_q && sda_q && !sda;
    wire stop_ev  = scl && scl_q && !sda_q && sda;
    wire rise     = scl && !scl_q;
    wire ack_rise = rise && pos == 4'h8;
    wire ack_hi   = scl && scl_q && pos == 4'h9;
    wire addr_ok  = sh[7:1] == {`SIRP_ADDR_HI, addr_lsb_strap} && !two_wire_port_disable;

    // Bit position within the byte and shifted line value
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            pos   <= 4'h0;
            sh    <= 8'h00;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            if (start_ev) begin
                pos <= 4'h0;
            end else if (rise) begin
                pos <= (pos == 4'h9) ? 4'h1 : pos + 4'h1;
                sh  <= {sh[6:0], sda};
            end
        end
    end

    // Transfer state: address byte, selection, direction, master refusal
    always_ff @(posedge clk) begin
        if (!resetn || start_ev) begin
            first  <= 1'b1;
            sel    <= 1'b0;
            rd     <= 1'b0;
            quiet  <= !resetn;
            nacked <= 1'b0;
        end else begin
            quiet  <= quiet || stop_ev;
            first  <= first && !(rise && pos == 4'h9);
            sel    <= (ack_rise && first) ? addr_ok : sel;
            rd     <= (ack_rise && first) ? sh[0] : rd;
            nacked <= nacked || (ack_rise && !first && rd && sda);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    AST_ADDR_ACK: assert property (ack_hi && first && sel |-> dev_sda_oe)
        else $error("own address not acknowledged");
    AST_WRITE_ACK: assert property (ack_hi && !first && sel && !rd |-> dev_sda_oe)
        else $error("written byte not acknowledged");
    AST_READ_ACK_FREE: assert property (ack_hi && !first && sel && rd |-> !dev_sda_oe)
        else $error("slave drives the master acknowledge slot");
    AST_FOREIGN_QUIET: assert property (!quiet && !sel && (pos == 4'h9 || !first)
        |-> !dev_sda_oe && !dev_scl_oe)
        else $error("slave drives the bus for a foreign address");
    AST_SDA_MOVES_LOW: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
        else $error("slave data changed while clock high");
    AST_NACK_RELEASE: assert property (nacked |-> !dev_sda_oe)
        else $error("data line held after refusal");
    AST_STRETCH_ENDS: assert property ($rose(dev_scl_oe) |-> ##[1:60] !dev_scl_oe)
        else $error("clock held low too long");
    AST_IDLE_QUIET: assert property (quiet |-> !dev_sda_oe && !dev_scl_oe)
        else $error("slave drives a free bus");
    AST_BUSY_SET: assert property (start_ev |-> ##[1:8] bus_busy)
        else $error("busy not raised after start");
    AST_BUSY_CLR: assert property (stop_ev |-> ##[1:8] !bus_busy)
        else $error("busy not cleared after stop");

    // Main scenarios reached
    cover property (start_ev && !quiet);
    cover property (nacked);
    cover property ($rose(dev_scl_oe));
    cover property (ack_hi && !first && sel && !rd);
endmodule : sirp_chk

/* File: test/tb_sensor_i2c_slave_register_port.sv */
// Self-checking bench joining the master and slave ends of the two-wire port
`timescale 1ns/100ps
module tb_sensor_i2c_slave_register_port;
    import sirp_pkg::*;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        strap = 1'b0;
    logic        dis = 1'b0;
    logic        cmd_valid = 1'b0;
    logic        cmd_read = 1'b0;
    logic        cmd_lsb = 1'b0;
    logic [7:0]  cmd_index = 8'h00;
    logic [3:0]  cmd_count = 4'h0;
    logic [7:0]  h_wdata = 8'h00;
    logic        d_rvalid = 1'b0;
    logic [7:0]  d_rdata = 8'h00;
    logic        cmd_ready, h_take, h_rvalid, done, nack_err, d_wstb, d_rreq, bus_busy;
    logic [7:0]  h_rdata, d_widx, d_wdata, d_ridx;
    logic [7:0]  mem [256];
    logic [7:0]  ref_mem [256];
    logic [7:0]  wq [$];
    logic [7:0]  rq [$];
    logic [15:0] ew [$];
    int          bad_count = 0;
    int          n_tests = 0;
    int          cyc = 0;

    sirp_if bus_if ();
    sirp_dev i_sirp_dev (.clk(clk), .resetn(resetn), .bus(bus_if.dev),
        .addr_lsb_strap(strap), .two_wire_port_disable(dis), .wr_strobe(d_wstb),
        .wr_index(d_widx), .wr_data(d_wdata), .rd_req(d_rreq), .rd_index(d_ridx),
        .rd_valid(d_rvalid), .rd_data(d_rdata), .bus_busy(bus_busy));
    sirp_host #(.QTR_CYC(5), .CNT_W(4)) i_sirp_host (.clk(clk), .resetn(resetn),
        .bus(bus_if.host), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_read(cmd_read), .cmd_addr_lsb(cmd_lsb), .cmd_index(cmd_index),
        .cmd_count(cmd_count), .wr_data(h_wdata), .wr_take(h_take), .rd_data(h_rdata),
        .rd_valid(h_rvalid), .done(done), .nack_err(nack_err));
    sirp_chk i_sirp_chk (.clk(clk), .resetn(resetn), .scl(bus_if.scl), .sda(bus_if.sda),
        .dev_scl_oe(bus_if.dev_scl_oe), .dev_sda_oe(bus_if.dev_sda_oe),
        .addr_lsb_strap(strap), .two_wire_port_disable(dis), .bus_busy(bus_busy));

    always #4 clk = ~clk;

    task automatic chk_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_byte

    task automatic chk_bit(input string name, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %b seen %b", name, exp, got);
        end
    endtask : chk_bit

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict

    // Refused when the address low bit misses the strap or the port is disabled
    function automatic logic refused(input logic lsb);
        return (lsb !== strap) || dis;
    endfunction : refused

    // One transfer through the master; expectations come from the shadow memory
    task automatic run_cmd(input logic rd, input logic lsb, input logic [7:0] idx,
                           input logic [3:0] cnt);
        logic       fgn;
        int         n;
        logic [7:0] b;
        fgn = refused(lsb);
        n = (cnt == 4'h0) ? 1 : int'(cnt);
        for (int k = 0; k < n; k++) begin
            b = 8'($urandom);
            if (rd && !fgn) rq.push_back(ref_mem[8'(idx + k)]);
            if (!rd) wq.push_back(b);
            if (!rd && !fgn) begin
                ew.push_back({8'(idx + k), b});
                ref_mem[8'(idx + k)] = b;
            end
        end
        cmd_read = rd;
        cmd_lsb = lsb;
        cmd_index = idx;
        cmd_count = cnt;
        h_wdata = wq.size() ? wq[0] : 8'h00;
        cmd_valid = 1'b1;
        do @(posedge clk); while (cmd_ready !== 1'b1);
        #1 cmd_valid = 1'b0;
        for (n = 0; n < 8000 && done !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        chk_bit("done", 1'b1, done);
        chk_bit("nack_err", fgn, nack_err);
        chk_byte("writes left", 8'h00, 8'(ew.size()));
        chk_byte("reads left", 8'h00, 8'(rq.size()));
        wq.delete();
    endtask : run_cmd

    // Slave user side writes and master read data, plus the hang limit
    always @(posedge clk) begin
        if (d_wstb === 1'b1) begin
            chk_byte("wr_index", ew.size() ? ew[0][15:8] : 8'hxx, d_widx);
            chk_byte("wr_data", ew.size() ? ew[0][7:0] : 8'hxx, d_wdata);
            if (ew.size()) void'(ew.pop_front());
            mem[d_widx] = d_wdata;
        end
        if (h_rvalid === 1'b1) begin
            chk_byte("rd_data", rq.size() ? rq[0] : 8'hxx, h_rdata);
            if (rq.size()) void'(rq.pop_front());
        end
        cyc++;
        if (cyc == 60000) begin
            bad_count++;
            print_verdict();
        end
    end

    // Next byte for the master after each take
    always @(posedge clk) begin
        if (h_take === 1'b1 && wq.size() > 0) begin
            void'(wq.pop_front());
            #1 h_wdata = wq.size() ? wq[0] : 8'h00;
        end
    end

    // Register answers after a random wait, which makes the slave stretch
    always @(posedge clk) begin
        if (d_rreq === 1'b1) begin
            repeat ($urandom_range(12, 1)) @(posedge clk);
            #1 d_rvalid = 1'b1;
            d_rdata = mem[d_ridx];
            @(posedge clk);
            #1 d_rvalid = 1'b0;
        end
    end

    // Reset, corner cases, then random transfers
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i) ^ 8'h5a;
            ref_mem[i] = 8'(i) ^ 8'h5a;
        end
        void'($urandom(31));
        repeat (3) @(posedge clk);
        #1 resetn = 1'b1;
        @(posedge clk);
        #1;
        run_cmd(1'b0, 1'b0, 8'hfe, 4'h3);
        run_cmd(1'b1, 1'b0, 8'hfe, 4'h3);
        run_cmd(1'b0, 1'b0, 8'h10, 4'h0);
        run_cmd(1'b1, 1'b1, 8'h10, 4'h1);
        strap = 1'b1;
        run_cmd(1'b1, 1'b1, 8'h10, 4'h1);
        run_cmd(1'b0, 1'b0, 8'h11, 4'h2);
        dis = 1'b1;
        run_cmd(1'b0, 1'b1, 8'h20, 4'h1);
        dis = 1'b0;
        for (int i = 0; i < 16; i++) begin
            strap = 1'($urandom);
            run_cmd(1'($urandom), ($urandom_range(3, 0) == 0) ? !strap : strap,
                    8'($urandom), 4'($urandom_range(4, 0)));
        end
        print_verdict();
    end
endmodule : tb_sensor_i2c_slave_register_port
